// >>> dcr_assertions.sv
// Protocol checker for the command pins between controller and device
`timescale 1ns/1ps
module dcr_assertions #(
  parameter int TREFI = 50
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic odt,
  input wire logic [dcr_pkg::BANK_W-1:0] ba,
  input wire logic [dcr_pkg::ADDR_W-1:0] addr
);
  // ----------------------------------------
  // Decode and helpers
  // ----------------------------------------
  logic col;
  logic rfr;
  logic act;
  logic idle;
  logic [15:0] gap_ff;
  logic owed_ff;
  assign col = !cs_n && ras_n && !cas_n;
  assign rfr = !cs_n && !ras_n && !cas_n && we_n;
  assign act = !cs_n && !ras_n && cas_n && we_n;
  assign idle = cs_n || (ras_n && cas_n && we_n);
  always_ff @(posedge i_clock) begin
    if (i_rst || rfr || !cke) gap_ff <= 16'h0000;
    else gap_ff <= gap_ff + 16'h0001;
    if (i_rst) owed_ff <= 1'b0;
    else if (rfr && cke) owed_ff <= 1'b0;
    else if ($rose(cke)) owed_ff <= 1'b1;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_col_spacing: assert property (col |=> !col)
    else $error("column commands too close");
  a_refresh_trfc: assert property (rfr && cke |=> !(rfr || act) [*3])
    else $error("command inside refresh cycle time");
  a_entry_encoding: assert property ($fell(cke) |-> rfr)
    else $error("clock enable dropped without refresh code");
  a_entry_odt_off: assert property ($fell(cke) |-> !odt)
    else $error("termination on at self refresh entry");
  a_exit_nop_only: assert property ($rose(cke) |-> idle [*5])
    else $error("command during self refresh exit");
  a_exit_cke_hold: assert property ($rose(cke) |-> (cke && !odt) [*5])
    else $error("clock enable or termination wrong after exit");
  a_gap_bound: assert property (gap_ff <= 9 * TREFI)
    else $error("refresh gap too long");
  a_reentry_ref: assert property ($fell(cke) |-> !owed_ff)
    else $error("self refresh re-entered without refresh");
  c_refresh: cover property (rfr && cke);
  c_entry: cover property ($fell(cke));
  c_column: cover property (col);
endmodule : dcr_assertions

// >>> dcr_ctrl.sv
// Controller side: issues commands, refresh, self refresh and spacing
`timescale 1ns/1ps
module dcr_ctrl #(
  parameter int TREFI = dcr_pkg::TREFI_CYC
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // User port
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Command pins
  dcr_if.ctrl bus
);

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;

  typedef enum logic [2:0] {
    ST_RUN, ST_SR, ST_EXIT, ST_NEED_REF
  } dcr_ctl_e;

  typedef struct packed {
    dcr_ctl_e fsm;
    logic cke;
    logic [3:0] pins;
    logic odt;
    logic [2:0] ba;
    logic [12:0] addr;
    logic [15:0] wait_cnt;
    logic [3:0] ccd;
    logic [15:0] ref_tmr;
    logic [3:0] owed;
    logic [31:0] rdata;
  } dcr_ctl_s;

  dcr_ctl_s st_ff;
  dcr_ctl_s nxt_st;
  logic busy;
  logic is_col;

  always_comb begin
    busy = (st_ff.wait_cnt != 16'h0000);
    // Command field: [3:0] cs,ras,cas,we [6:4] ba [19:7] addr [20] sr req
    is_col = !i_wdata[3] && i_wdata[2] && !i_wdata[1];
    nxt_st = st_ff;
    nxt_st.pins = 4'hF;
    nxt_st.rdata = 32'h0000_0000;
    if (busy) nxt_st.wait_cnt = 16'(st_ff.wait_cnt - 16'h1);
    if (st_ff.ccd != 4'h0) nxt_st.ccd = 4'(st_ff.ccd - 4'h1);
    if (st_ff.ref_tmr == 16'(TREFI - 1)) begin
      nxt_st.ref_tmr = 16'h0000;
      if (st_ff.owed < 4'(dcr_pkg::POSTED_MAX + 1))
        nxt_st.owed = 4'(st_ff.owed + 4'h1);
    end else begin
      nxt_st.ref_tmr = 16'(st_ff.ref_tmr + 16'h1);
    end
    unique case (st_ff.fsm)
      ST_RUN, ST_NEED_REF: begin
        // Force at eight owed so the gap stays under nine intervals
        if (st_ff.owed >= 4'(dcr_pkg::POSTED_MAX) && !busy) begin
          nxt_st.pins = 4'b0001;
          nxt_st.owed = 4'(st_ff.owed - 4'h1);
          nxt_st.wait_cnt = 16'(dcr_pkg::TRFC_CYC);
          nxt_st.fsm = ST_RUN;
        end else if (i_wr && i_addr == REG_CMD && !busy) begin
          if (i_wdata[20] && st_ff.fsm == ST_RUN) begin
            nxt_st.odt = 1'b0;
            nxt_st.cke = 1'b0;
            nxt_st.pins = 4'b0001;
            nxt_st.fsm = ST_SR;
          end else if (!i_wdata[20]) begin
            if (!(is_col && st_ff.ccd != 4'h0)) begin
              nxt_st.pins = i_wdata[3:0];
              nxt_st.ba = i_wdata[6:4];
              nxt_st.addr = i_wdata[19:7];
              if (is_col) nxt_st.ccd = 4'(dcr_pkg::TCCD_CYC - 4'h1);
              if (i_wdata[3:0] == 4'b0001) begin
                nxt_st.wait_cnt = 16'(dcr_pkg::TRFC_CYC);
                nxt_st.fsm = ST_RUN;
                if (st_ff.owed != 4'h0) nxt_st.owed = 4'(st_ff.owed - 4'h1);
              end
            end
          end
        end
      end
      ST_SR: begin
        nxt_st.cke = 1'b0;
        nxt_st.owed = 4'h0;
        if (i_wr && i_addr == REG_CMD && !i_wdata[20]) begin
          nxt_st.cke = 1'b1;
          nxt_st.pins = 4'hF;
          nxt_st.wait_cnt = 16'(dcr_pkg::TXSNR_CYC);
          nxt_st.fsm = ST_EXIT;
        end
      end
      ST_EXIT: begin
        nxt_st.cke = 1'b1;
        nxt_st.pins = 4'hF;
        if (!busy) nxt_st.fsm = ST_NEED_REF;
      end
      default: nxt_st.fsm = ST_RUN;
    endcase
    if (i_rd) begin
      if (i_addr == REG_STATUS)
        nxt_st.rdata = {24'h00_0000, st_ff.owed, busy,
                        st_ff.fsm == ST_SR, st_ff.fsm == ST_NEED_REF, st_ff.cke};
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_ff <= '0;
      st_ff.fsm <= ST_RUN;
      st_ff.cke <= 1'b1;
      st_ff.pins <= 4'hF;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bus.cke = st_ff.cke;
  assign bus.cs_n = st_ff.pins[3];
  assign bus.ras_n = st_ff.pins[2];
  assign bus.cas_n = st_ff.pins[1];
  assign bus.we_n = st_ff.pins[0];
  assign bus.odt = st_ff.odt;
  assign bus.ba = st_ff.ba;
  assign bus.addr = st_ff.addr;
  assign o_rdata = st_ff.rdata;

endmodule : dcr_ctrl

// >>> dcr_device.sv
// DDR2 device side: command decode, bank state, auto-precharge, refresh
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module dcr_device #(
  parameter int SR_PERIOD = dcr_pkg::SELF_REF_PERIOD
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Mode settings
  input wire logic [2:0] i_al,
  input wire logic [2:0] i_cl,
  input wire logic [2:0] i_wr,
  input wire logic i_bl8,
  // Command pins
  dcr_if.mem bus,
  // Observed state
  output logic [dcr_pkg::NUM_BANKS-1:0] o_bank_open,
  output logic o_self_refresh,
  output logic o_dll_on,
  output logic o_col_valid,
  output logic o_col_write,
  output logic [dcr_pkg::BANK_W-1:0] o_col_bank,
  output logic [dcr_pkg::COL_W-1:0] o_col_addr,
  output logic [dcr_pkg::COL_W-1:0] o_seg_base,
  output logic [3:0] o_read_lat,
  output logic [3:0] o_write_lat,
  output logic [15:0] o_refresh_row,
  output logic o_refresh_pulse
);

  localparam int NB = dcr_pkg::NUM_BANKS;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [NB-1:0] open;
    logic [NB-1:0] ap_pend;
    logic [NB-1:0][4:0] ap_cnt;
    logic sref;
    logic dll;
    logic [7:0] sr_tmr;
    logic [15:0] row;
    logic ref_p;
    // Posted column command delay line, one slot per AL cycle
    logic [6:0] pv;
    logic [6:0] pw;
    logic [6:0][dcr_pkg::BANK_W-1:0] pb;
    logic [6:0][dcr_pkg::COL_W-1:0] pc;
    logic cv;
    logic cw;
    logic [dcr_pkg::BANK_W-1:0] cb;
    logic [dcr_pkg::COL_W-1:0] ca;
    logic [dcr_pkg::COL_W-1:0] seg;
    logic [3:0] rl;
    logic [3:0] wl;
  } dcr_dev_s;

  dcr_dev_s st_ff;
  dcr_dev_s nxt_st;

  dcr_pkg::dcr_cmd_e cmd;
  logic [2:0] al_eff;
  logic [3:0] half_bl;

  always_comb begin
    cmd = dcr_pkg::dcr_decode({bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n});
    al_eff = (i_al > dcr_pkg::AL_MAX) ? dcr_pkg::AL_MAX : i_al;
    half_bl = i_bl8 ? (dcr_pkg::BL8 >> 1) : (dcr_pkg::BL4 >> 1);
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ref_p = 1'b0;
    nxt_st.cv = 1'b0;
    nxt_st.rl = 4'({1'b0, al_eff} + {1'b0, i_cl});
    nxt_st.wl = 4'(nxt_st.rl - 4'h1);
    // Auto-precharge countdowns
    for (int b = 0; b < NB; b++) begin
      if (st_ff.ap_pend[b]) begin
        if (st_ff.ap_cnt[b] <= 5'h1) begin
          nxt_st.ap_pend[b] = 1'b0;
          nxt_st.open[b] = 1'b0;
        end else begin
          nxt_st.ap_cnt[b] = 5'(st_ff.ap_cnt[b] - 5'h1);
        end
      end
    end
    // Posted CAS delay line
    nxt_st.pv = {st_ff.pv[5:0], 1'b0};
    nxt_st.pw = {st_ff.pw[5:0], 1'b0};
    nxt_st.pb = {st_ff.pb[5:0], 3'h0};
    nxt_st.pc = {st_ff.pc[5:0], 10'h000};
    if (al_eff != 3'h0 && st_ff.pv[al_eff - 3'h1]) begin
      nxt_st.cv = 1'b1;
      nxt_st.cw = st_ff.pw[al_eff - 3'h1];
      nxt_st.cb = st_ff.pb[al_eff - 3'h1];
      nxt_st.ca = st_ff.pc[al_eff - 3'h1];
    end
    if (st_ff.sref) begin
      // Only CKE and a NOP or deselect matter while in self refresh
      if (st_ff.sr_tmr == 8'(SR_PERIOD - 1)) begin
        nxt_st.sr_tmr = 8'h00;
        nxt_st.row = 16'(st_ff.row + 16'h1);
      end else begin
        nxt_st.sr_tmr = 8'(st_ff.sr_tmr + 8'h1);
      end
      if (bus.cke && (bus.cs_n || cmd == dcr_pkg::CMD_NOP)) begin
        nxt_st.sref = 1'b0;
        nxt_st.dll = 1'b1;
      end
    end else if (bus.cke && !bus.cs_n) begin
      unique case (cmd)
        dcr_pkg::CMD_ACTIVATE: nxt_st.open[bus.ba] = 1'b1;
        dcr_pkg::CMD_READ, dcr_pkg::CMD_WRITE: begin
          if (bus.addr[dcr_pkg::AP_BIT]) begin
            nxt_st.ap_pend[bus.ba] = 1'b1;
            if (cmd == dcr_pkg::CMD_READ)
              nxt_st.ap_cnt[bus.ba] = 5'({2'b00, al_eff} + {1'b0, half_bl});
            else
              nxt_st.ap_cnt[bus.ba] = 5'({1'b0, nxt_st.wl}
                + {1'b0, half_bl} + {2'b00, i_wr});
          end
          nxt_st.seg = i_bl8 ? {bus.addr[9:3], 3'b000}
                             : {bus.addr[9:2], 2'b00};
          if (al_eff == 3'h0) begin
            nxt_st.cv = 1'b1;
            nxt_st.cw = (cmd == dcr_pkg::CMD_WRITE);
            nxt_st.cb = bus.ba;
            nxt_st.ca = bus.addr[dcr_pkg::COL_W-1:0];
          end else begin
            nxt_st.pv[0] = 1'b1;
            nxt_st.pw[0] = (cmd == dcr_pkg::CMD_WRITE);
            nxt_st.pb[0] = bus.ba;
            nxt_st.pc[0] = bus.addr[dcr_pkg::COL_W-1:0];
          end
        end
        dcr_pkg::CMD_PRECHARGE: begin
          if (bus.addr[dcr_pkg::AP_BIT]) begin
            nxt_st.open = '0;
            nxt_st.ap_pend = '0;
          end else begin
            nxt_st.open[bus.ba] = 1'b0;
          end
        end
        dcr_pkg::CMD_REFRESH: begin
          nxt_st.row = 16'(st_ff.row + 16'h1);
          nxt_st.ref_p = 1'b1;
          nxt_st.open = '0;
        end
        dcr_pkg::CMD_NOP, dcr_pkg::CMD_DESELECT,
        dcr_pkg::CMD_OTHER: ;
      endcase
    end else if (!bus.cke && !bus.cs_n && cmd == dcr_pkg::CMD_REFRESH) begin
      nxt_st.sref = 1'b1;
      nxt_st.dll = 1'b0;
      nxt_st.sr_tmr = 8'h00;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_ff <= '0;
      st_ff.dll <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_bank_open = st_ff.open;
  assign o_self_refresh = st_ff.sref;
  assign o_dll_on = st_ff.dll;
  assign o_col_valid = st_ff.cv;
  assign o_col_write = st_ff.cw;
  assign o_col_bank = st_ff.cb;
  assign o_col_addr = st_ff.ca;
  assign o_seg_base = st_ff.seg;
  assign o_read_lat = st_ff.rl;
  assign o_write_lat = st_ff.wl;
  assign o_refresh_row = st_ff.row;
  assign o_refresh_pulse = st_ff.ref_p;

endmodule : dcr_device

// >>> dcr_if.sv
// Command pins between memory controller and DDR2 device
`timescale 1ns/1ps
interface dcr_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic odt;
  logic [dcr_pkg::BANK_W-1:0] ba;
  logic [dcr_pkg::ADDR_W-1:0] addr;

  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr);
  modport mem (input cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr);
endinterface : dcr_if

// >>> dcr_pkg.sv
// Shared constants and types for the DDR2 command and refresh logic
package dcr_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int BANK_W = 3;
  localparam int ADDR_W = 13;
  localparam int COL_W = 10;
  localparam int NUM_BANKS = 8;
  localparam int AP_BIT = 10;

  // ----------------------------------------
  // Latency and burst settings
  // ----------------------------------------
  localparam logic [2:0] AL_MAX = 3'h6;
  localparam logic [2:0] AL_RESET = 3'h0;
  localparam logic [2:0] CL_RESET = 3'h3;
  localparam logic [2:0] WR_RESET = 3'h3;
  localparam logic [3:0] BL4 = 4'h4;
  localparam logic [3:0] BL8 = 4'h8;
  localparam logic [3:0] TCCD_CYC = 4'h2;

  // ----------------------------------------
  // Timing (ns) and derived cycles at 25 MHz
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int TXSNR_NS = 200;
  localparam int TRFC_NS = 128;
  localparam int TREFI_NS = 7800;
  localparam int TXSNR_CYC = (TXSNR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRFC_CYC = (TRFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TREFI_CYC = TREFI_NS / CLK_PERIOD_NS;
  localparam int POSTED_MAX = 8;
  localparam int SELF_REF_PERIOD = 64;

  // ----------------------------------------
  // Decoded commands
  // ----------------------------------------
  typedef enum logic [2:0] {
    CMD_DESELECT, CMD_NOP, CMD_READ, CMD_WRITE,
    CMD_PRECHARGE, CMD_REFRESH, CMD_ACTIVATE, CMD_OTHER
  } dcr_cmd_e;

  // Encoding: cs_n, ras_n, cas_n, we_n
  function automatic dcr_cmd_e dcr_decode(input logic [3:0] pins);
    dcr_cmd_e c;
    c = CMD_OTHER;
    if (pins[3]) c = CMD_DESELECT;
    else begin
      unique case (pins[2:0])
        3'b111: c = CMD_NOP;
        3'b101: c = CMD_READ;
        3'b100: c = CMD_WRITE;
        3'b010: c = CMD_PRECHARGE;
        3'b001: c = CMD_REFRESH;
        3'b011: c = CMD_ACTIVATE;
        default: c = CMD_OTHER;
      endcase
    end
    return c;
  endfunction : dcr_decode

endpackage : dcr_pkg

// >>> ddr2_command_and_refresh_logic_tb_top.sv
// Testbench for the DDR2 controller and device pair
`timescale 1ns/1ps
module ddr2_command_and_refresh_logic_tb_top;
  localparam logic [3:0] CRD = 4'h5;
  localparam logic [3:0] CWR = 4'h4;
  localparam logic [3:0] CACT = 4'h3;
  localparam logic [3:0] CPRE = 4'h2;
  localparam logic [3:0] CREF = 4'h1;
  localparam logic [3:0] CNOP = 4'h7;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [2:0] al = 3'h0;
  logic bl8 = 1'b0;
  logic [31:0] rdata;
  logic [7:0] bopen;
  logic sref, dll, cval, cwr, rpulse;
  logic [2:0] cbank;
  logic [9:0] caddr, seg;
  logic [3:0] rlat, wlat;
  logic [15:0] row;
  int fails = 0;
  int check_count = 0;
  int ccnt = 0;
  int rcnt = 0;
  always #20 i_clock = ~i_clock;
  dcr_if i_dcr_if ();
  dcr_ctrl #(.TREFI(50)) i_dcr_ctrl (.i_clock(i_clock), .i_rst(i_rst),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .bus(i_dcr_if));
  dcr_device #(.SR_PERIOD(8)) i_dcr_device (.i_clock(i_clock),
    .i_rst(i_rst), .i_al(al), .i_cl(3'h3), .i_wr(3'h3), .i_bl8(bl8),
    .bus(i_dcr_if), .o_bank_open(bopen), .o_self_refresh(sref),
    .o_dll_on(dll), .o_col_valid(cval), .o_col_write(cwr),
    .o_col_bank(cbank), .o_col_addr(caddr), .o_seg_base(seg),
    .o_read_lat(rlat), .o_write_lat(wlat), .o_refresh_row(row),
    .o_refresh_pulse(rpulse));
  dcr_assertions #(.TREFI(50)) i_dcr_assertions (.i_clock(i_clock),
    .i_rst(i_rst), .cke(i_dcr_if.cke), .cs_n(i_dcr_if.cs_n),
    .ras_n(i_dcr_if.ras_n), .cas_n(i_dcr_if.cas_n),
    .we_n(i_dcr_if.we_n), .odt(i_dcr_if.odt), .ba(i_dcr_if.ba),
    .addr(i_dcr_if.addr));
  always @(posedge i_clock) begin
    if (cval === 1'b1) ccnt++;
    if (rpulse === 1'b1) rcnt++;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  function automatic logic [31:0] mk(input logic [3:0] c,
    input logic [2:0] b, input logic [12:0] a, input logic s);
    return {11'h000, s, a, b, c};
  endfunction : mk
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %0t: got %h, want %h", $time, s, e);
    end
  endtask : chk
  task automatic cmd(input logic [31:0] w);
    @(posedge i_clock);
    wr <= 1'b1;
    addr <= 4'h0;
    wdata <= w;
    @(posedge i_clock);
    wr <= 1'b0;
  endtask : cmd
  task automatic gap(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : gap
  task automatic rdst(output logic [31:0] d);
    @(posedge i_clock);
    rd <= 1'b1;
    addr <= 4'h1;
    @(posedge i_clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rdst
  task automatic report_and_stop();
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_col(input logic w, input logic [2:0] a, input logic b8);
    al <= a;
    bl8 <= b8;
    cmd(mk(CACT, 3'h5, 13'h0000, 1'b0));
    gap(8);
    cmd(mk(w ? CWR : CRD, 3'h5, 13'h01a7, 1'b0));
    gap(1 + a);
    chk(cval, 1'b1);
    chk({cwr, cbank, caddr}, {w, 3'h5, 10'h1a7});
    chk(seg, b8 ? 10'h1a0 : 10'h1a4);
    chk({rlat, wlat}, {a + 4'h3, a + 4'h2});
    gap(8);
    chk(bopen[5], 1'b1);
  endtask : t_col
  task automatic t_autopre(input logic w);
    al <= 3'h2;
    bl8 <= 1'b1;
    cmd(mk(CACT, 3'h2, 13'h0000, 1'b0));
    gap(8);
    cmd(mk(w ? CWR : CRD, 3'h2, 13'h0400, 1'b0));
    gap(2);
    chk(bopen[2], 1'b1);
    // Read closes AL+BL/2=6 edges on, write WL+BL/2+WR=11
    gap(w ? 9 : 4);
    chk(bopen[2], 1'b1);
    gap(1);
    chk(bopen[2], 1'b0);
  endtask : t_autopre
  task automatic t_pall();
    cmd(mk(CACT, 3'h1, 13'h0000, 1'b0));
    gap(8);
    cmd(mk(CACT, 3'h6, 13'h0000, 1'b0));
    gap(8);
    chk(bopen[1] & bopen[6], 1'b1);
    cmd(mk(CPRE, 3'h3, 13'h0400, 1'b0));
    gap(8);
    chk(bopen, 8'h00);
  endtask : t_pall
  task automatic t_ignored();
    int n;
    n = ccnt;
    cmd(mk(4'hd, 3'h4, 13'h0010, 1'b0));
    cmd(mk(CNOP, 3'h4, 13'h0010, 1'b0));
    cmd(mk(4'hb, 3'h4, 13'h0000, 1'b0));
    gap(8);
    chk(ccnt, n);
    chk(bopen[4], 1'b0);
  endtask : t_ignored
  task automatic t_tccd();
    int n;
    cmd(mk(CACT, 3'h0, 13'h0000, 1'b0));
    gap(8);
    n = ccnt;
    @(posedge i_clock);
    wr <= 1'b1;
    wdata <= mk(CRD, 3'h0, 13'h0010, 1'b0);
    @(posedge i_clock);
    wdata <= mk(CRD, 3'h0, 13'h0020, 1'b0);
    @(posedge i_clock);
    wr <= 1'b0;
    gap(10);
    chk(ccnt, n + 1);
    chk(caddr, 10'h010);
  endtask : t_tccd
  task automatic t_refresh();
    int p;
    logic [15:0] r;
    p = rcnt;
    r = row;
    cmd(mk(CREF, 3'h7, 13'h1fff, 1'b0));
    gap(8);
    chk(rcnt > p, 1'b1);
    chk(row - r, rcnt - p);
    p = rcnt;
    gap(600);
    chk(rcnt - p >= 4, 1'b1);
  endtask : t_refresh
  task automatic t_sref();
    logic [31:0] d;
    logic [15:0] r;
    // Enter just after a forced refresh so none collides with entry
    while (rpulse !== 1'b1) @(posedge i_clock);
    gap(8);
    cmd(mk(CREF, 3'h0, 13'h0000, 1'b1));
    gap(4);
    chk({i_dcr_if.cke, sref, dll}, 3'b010);
    rdst(d);
    chk({d[2], d[0]}, 2'b10);
    r = row;
    gap(40);
    chk(row != r, 1'b1);
    cmd(mk(CNOP, 3'h0, 13'h0000, 1'b0));
    gap(12);
    chk({i_dcr_if.cke, sref, dll}, 3'b101);
    cmd(mk(CREF, 3'h0, 13'h0000, 1'b1));
    gap(20);
    cmd(mk(CNOP, 3'h0, 13'h0000, 1'b0));
    gap(12);
    chk(i_dcr_if.cke, 1'b1);
  endtask : t_sref
  initial begin
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    t_col(1'b0, 3'h2, 1'b1);
    t_col(1'b1, 3'h0, 1'b0);
    t_col(1'b1, 3'h6, 1'b0);
    t_autopre(1'b0);
    t_autopre(1'b1);
    t_pall();
    t_ignored();
    t_tccd();
    t_refresh();
    t_sref();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge i_clock);
    fails++;
    report_and_stop();
  end
endmodule : ddr2_command_and_refresh_logic_tb_top
